/* core/l1ac_pkg.sv */
// Constants, codes and types for the layer 1 activation control block
package l1ac_pkg;

  // ==========================================================
  // Clock and line timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_S = 1000000000;
  localparam int CP_RATE_HZ = 96000;
  localparam int SP_RATE_HZ = 2000;
  localparam int LINE_RATE_BPS = 192000;
  // One pulse each half period, alternating polarity
  localparam int CP_PULSE_CYC = NS_PER_S / (CP_RATE_HZ * 2 * CLK_PERIOD_NS);
  localparam int SP_GAP_CYC = NS_PER_S / (SP_RATE_HZ * 2 * CLK_PERIOD_NS);
  localparam int BIT_CYC = NS_PER_S / (LINE_RATE_BPS * CLK_PERIOD_NS);
  localparam int DEACT_TIME_MS = 16;
  localparam int INFO0_FRAMES = 64;
  localparam int FA_LOSS_FRAMES = 2;
  localparam int FA_REGAIN_FRAMES = 5;

  // ==========================================================
  // Command codes
  localparam logic [3:0] CMD_CLOCK_ON = 4'h0;
  localparam logic [3:0] CMD_L1_RESET = 4'h1;
  localparam logic [3:0] CMD_SINGLE_PULSE = 4'h2;
  localparam logic [3:0] CMD_CONT_PULSE = 4'h4;
  localparam logic [3:0] CMD_ACT_CLASS1 = 4'h8;
  localparam logic [3:0] CMD_ACT_CLASS2 = 4'h9;
  localparam logic [3:0] CMD_ANALOG_LOOP = 4'ha;
  localparam logic [3:0] CMD_DEACT_CLK_OFF = 4'hf;
  localparam logic [3:0] CMD_RESET_VALUE = CMD_DEACT_CLK_OFF;

  // ==========================================================
  // Indication codes
  localparam logic [3:0] IND_LINE_DEACT_REQ = 4'h0;
  localparam logic [3:0] IND_SIGNAL_SEEN = 4'h4;
  localparam logic [3:0] IND_CLOCK_ON = 4'h7;
  localparam logic [3:0] IND_LINE_ACT_REQ = 4'h8;
  localparam logic [3:0] IND_TEST_ACTIVE = 4'ha;
  localparam logic [3:0] IND_TEST_SIGNAL_SEEN = 4'hb;
  localparam logic [3:0] IND_ACTIVE_CLASS1 = 4'hc;
  localparam logic [3:0] IND_ACTIVE_CLASS2 = 4'hd;
  localparam logic [3:0] IND_CLOCKS_OFF = 4'hf;

  // ==========================================================
  // D channel priority levels
  localparam logic [3:0] PRIO_CLASS1_NORMAL = 4'h8;
  localparam logic [3:0] PRIO_CLASS1_LOWER = 4'h9;
  localparam logic [3:0] PRIO_CLASS2_NORMAL = 4'ha;
  localparam logic [3:0] PRIO_CLASS2_LOWER = 4'hb;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_F3_CLK_OFF = 4'h0,
    ST_F3_CLK_ON = 4'h1,
    ST_F4_AWAIT_SIG = 4'h3,
    ST_F5_IDENTIFY = 4'h2,
    ST_F6_SYNC = 4'h6,
    ST_F7_ACTIVE = 4'h7,
    ST_F8_LOST_FRAME = 4'h5,
    ST_F3_AWAIT_DEACT = 4'h4,
    ST_L1_RESET = 4'hc,
    ST_LOOP_INIT = 4'hd,
    ST_LOOP_ACTIVE = 4'hf,
    ST_TEST_PULSE = 4'he
  } l1ac_state_t;

  typedef enum logic [2:0] {
    RX_INFO0 = 3'h0,
    RX_ANY = 3'h1,
    RX_INFO2 = 3'h2,
    RX_INFO3 = 3'h3,
    RX_INFO4 = 3'h4
  } l1ac_rx_info_t;

  typedef enum logic [1:0] {
    TX_INFO0 = 2'h0,
    TX_INFO1 = 2'h1,
    TX_INFO3 = 2'h3
  } l1ac_tx_info_t;

  typedef enum logic [1:0] {
    PULSE_NONE = 2'h0,
    PULSE_CONT = 2'h1,
    PULSE_SINGLE = 2'h2
  } l1ac_pulse_mode_t;

endpackage

/* core/l1ac_pulse_gen.sv */
// Test pulse generator: continuous and isolated alternating pulses
`timescale 1ns/100ps
module l1ac_pulse_gen import l1ac_pkg::*; #(
  parameter int CP_CYC = CP_PULSE_CYC,
  parameter int SP_CYC = SP_GAP_CYC,
  parameter int W_CYC = BIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire l1ac_pulse_mode_t mode,
  output logic pulse_pos_q,
  output logic pulse_neg_q
);

  localparam int CW = $clog2(SP_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic pol_q;
  logic wrap;

  assign wrap = (mode == PULSE_CONT) ? (cnt_q >= CW'(CP_CYC - 1))
                                     : (cnt_q >= CW'(SP_CYC - 1));

  // ==========================================================
  // Spacing counter and polarity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      pol_q <= 1'b0;
    end else if (mode == PULSE_NONE) begin
      cnt_q <= '0;
      pol_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= '0;
      pol_q <= ~pol_q;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // ==========================================================
  // Line pulse drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_pos_q <= 1'b0;
      pulse_neg_q <= 1'b0;
    end else if (mode == PULSE_CONT) begin
      // No gaps: polarity flips every pulse width
      pulse_pos_q <= ~pol_q;
      pulse_neg_q <= pol_q;
    end else if (mode == PULSE_SINGLE) begin
      // One bit-time pulse at the start of each gap
      pulse_pos_q <= ~pol_q && (cnt_q < CW'(W_CYC));
      pulse_neg_q <= pol_q && (cnt_q < CW'(W_CYC));
    end else begin
      pulse_pos_q <= 1'b0;
      pulse_neg_q <= 1'b0;
    end
  end

endmodule // l1ac_pulse_gen

/* core/l1ac_top.sv */
// Layer 1 activation control: commands, indications, framing, D access
`timescale 1ns/100ps
module l1ac_top import l1ac_pkg::*; #(
  parameter int SP_CYC = SP_GAP_CYC,
  parameter int INFO0_DEACT_FRAMES = INFO0_FRAMES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_wr,
  input wire logic [3:0] cmd_data,
  input wire l1ac_rx_info_t rx_info,
  input wire logic rx_frame_tick,
  input wire logic rx_frame_ok,
  input wire logic rx_fa_bit,
  input wire logic rx_level,
  input wire logic d_bit_strobe,
  input wire logic d_tx_bit,
  input wire logic d_echo_bit,
  input wire logic d_tx_busy,
  input wire logic d_frame_done,
  output logic [3:0] command_code_register,
  output logic [3:0] indication_code_register,
  output logic ind_valid_q,
  output l1ac_state_t state_q,
  output l1ac_tx_info_t tx_info_q,
  output logic tx_line_en_q,
  output logic loop_en_q,
  output logic awake_det_en_q,
  output logic clocks_en_q,
  output logic tx_fa_q,
  output logic frame_aligned_q,
  output logic tx_pulse_pos_q,
  output logic tx_pulse_neg_q,
  output logic [3:0] d_prio_q,
  output logic d_access_ok_q,
  output logic d_collision_q,
  output logic d_stop_q
);

  localparam int FC_W = $clog2(INFO0_DEACT_FRAMES + 1);
  localparam logic [FC_W-1:0] INFO0_LIMIT = FC_W'(INFO0_DEACT_FRAMES);

  l1ac_state_t state_d;
  logic [3:0] cmd_q;
  logic class2_q;
  logic [FC_W-1:0] info0_cnt_q;
  logic [2:0] bad_cnt_q;
  logic [2:0] good_cnt_q;
  logic aligned_d;
  logic info0_long;
  logic non_info0;
  l1ac_pulse_mode_t pulse_mode_q;
  logic [3:0] ones_cnt_q;
  logic lower_q;
  logic collide;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] ind_of(input l1ac_state_t st,
                                        input logic cls2,
                                        input logic lvl);
    begin
      case (st)
        ST_F3_CLK_OFF: ind_of = IND_CLOCKS_OFF;
        ST_F3_CLK_ON: ind_of = IND_CLOCK_ON;
        ST_F4_AWAIT_SIG: ind_of = IND_CLOCK_ON;
        ST_F3_AWAIT_DEACT: ind_of = IND_LINE_DEACT_REQ;
        ST_F5_IDENTIFY: ind_of = IND_SIGNAL_SEEN;
        ST_F8_LOST_FRAME: ind_of = IND_SIGNAL_SEEN;
        ST_F6_SYNC: ind_of = IND_LINE_ACT_REQ;
        ST_F7_ACTIVE: ind_of = cls2 ? IND_ACTIVE_CLASS2
                                    : IND_ACTIVE_CLASS1;
        ST_LOOP_INIT: ind_of = IND_CLOCK_ON;
        ST_LOOP_ACTIVE,
        ST_TEST_PULSE: ind_of = lvl ? IND_TEST_SIGNAL_SEEN
                                    : IND_TEST_ACTIVE;
        default: ind_of = IND_CLOCKS_OFF;
      endcase
    end
  endfunction

  function automatic logic is_test_cmd(input logic [3:0] c);
    begin
      is_test_cmd = (c == CMD_CONT_PULSE) || (c == CMD_SINGLE_PULSE) ||
                    (c == CMD_ANALOG_LOOP);
    end
  endfunction

  // Awake detector is off in layer 1 reset, so the far end cannot wake us
  assign non_info0 = (rx_info != RX_INFO0) && (state_q != ST_L1_RESET);
  assign info0_long = (info0_cnt_q >= INFO0_LIMIT);

  // ==========================================================
  // Command register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= CMD_RESET_VALUE;
    end else if (cmd_wr) begin
      cmd_q <= cmd_data;
    end
  end

  // Class is only changed by the two activate commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      class2_q <= 1'b0;
    end else if (cmd_q == CMD_ACT_CLASS1) begin
      class2_q <= 1'b0;
    end else if (cmd_q == CMD_ACT_CLASS2) begin
      class2_q <= 1'b1;
    end
  end

  // ==========================================================
  // Frame alignment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bad_cnt_q <= '0;
      good_cnt_q <= '0;
    end else if (rx_frame_tick) begin
      if (rx_frame_ok) begin
        bad_cnt_q <= '0;
        if (good_cnt_q < 3'(FA_REGAIN_FRAMES)) begin
          good_cnt_q <= good_cnt_q + 3'h1;
        end
      end else begin
        good_cnt_q <= '0;
        if (bad_cnt_q < 3'(FA_LOSS_FRAMES)) begin
          bad_cnt_q <= bad_cnt_q + 3'h1;
        end
      end
    end
  end

  always_comb begin
    aligned_d = frame_aligned_q;
    if (rx_frame_tick) begin
      if (frame_aligned_q && !rx_frame_ok &&
          bad_cnt_q == 3'(FA_LOSS_FRAMES - 1)) begin
        aligned_d = 1'b0;
      end else if (!frame_aligned_q && rx_frame_ok &&
                   good_cnt_q == 3'(FA_REGAIN_FRAMES - 1)) begin
        aligned_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_aligned_q <= 1'b0;
    end else begin
      frame_aligned_q <= aligned_d;
    end
  end

  // Auxiliary framing bit echoed back in our next frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_fa_q <= 1'b0;
    end else if (rx_frame_tick) begin
      tx_fa_q <= rx_fa_bit;
    end
  end

  // ==========================================================
  // INFO 0 persistence, counted in received frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      info0_cnt_q <= '0;
    end else if (rx_info != RX_INFO0) begin
      info0_cnt_q <= '0;
    end else if (rx_frame_tick && !info0_long) begin
      info0_cnt_q <= info0_cnt_q + FC_W'(1);
    end
  end

  // ==========================================================
  // Activation state machine
  always_comb begin
    state_d = state_q;
    if (cmd_q == CMD_L1_RESET) begin
      state_d = ST_L1_RESET;
    end else begin
      case (state_q)
        ST_L1_RESET: begin
          if (cmd_q == CMD_CLOCK_ON) state_d = ST_F3_CLK_ON;
        end
        ST_F3_CLK_OFF: begin
          if (non_info0) state_d = ST_F5_IDENTIFY;
          else if (cmd_q == CMD_CLOCK_ON) state_d = ST_F3_CLK_ON;
        end
        ST_F3_CLK_ON: begin
          if (non_info0) begin
            state_d = ST_F5_IDENTIFY;
          end else if (cmd_q == CMD_ACT_CLASS1 ||
                       cmd_q == CMD_ACT_CLASS2) begin
            state_d = ST_F4_AWAIT_SIG;
          end else if (cmd_q == CMD_DEACT_CLK_OFF) begin
            state_d = ST_F3_CLK_OFF;
          end else if (cmd_q == CMD_ANALOG_LOOP) begin
            state_d = ST_LOOP_INIT;
          end else if (is_test_cmd(cmd_q)) begin
            state_d = ST_TEST_PULSE;
          end
        end
        ST_F4_AWAIT_SIG: begin
          if (non_info0) state_d = ST_F5_IDENTIFY;
          else if (cmd_q == CMD_DEACT_CLK_OFF) state_d = ST_F3_CLK_OFF;
        end
        ST_F3_AWAIT_DEACT: begin
          if (non_info0) state_d = ST_F5_IDENTIFY;
          else if (cmd_q == CMD_DEACT_CLK_OFF) state_d = ST_F3_CLK_OFF;
          else if (cmd_q == CMD_CLOCK_ON) state_d = ST_F3_CLK_ON;
        end
        ST_F5_IDENTIFY: begin
          if (info0_long) state_d = ST_F3_AWAIT_DEACT;
          else if (rx_info == RX_INFO4) state_d = ST_F7_ACTIVE;
          else if (rx_info == RX_INFO2) state_d = ST_F6_SYNC;
        end
        ST_F6_SYNC: begin
          if (info0_long) state_d = ST_F3_AWAIT_DEACT;
          else if (!frame_aligned_q) state_d = ST_F8_LOST_FRAME;
          else if (rx_info == RX_INFO4) state_d = ST_F7_ACTIVE;
        end
        ST_F7_ACTIVE: begin
          if (info0_long) begin
            state_d = ST_F3_AWAIT_DEACT;
          end else if (!frame_aligned_q) begin
            state_d = ST_F8_LOST_FRAME;
          end else if (cmd_q == CMD_ANALOG_LOOP) begin
            state_d = ST_LOOP_INIT;
          end else if (is_test_cmd(cmd_q)) begin
            state_d = ST_TEST_PULSE;
          end
        end
        ST_F8_LOST_FRAME: begin
          if (info0_long) state_d = ST_F3_AWAIT_DEACT;
          else if (frame_aligned_q && rx_info == RX_INFO4)
            state_d = ST_F7_ACTIVE;
          else if (frame_aligned_q && rx_info == RX_INFO2)
            state_d = ST_F6_SYNC;
        end
        ST_LOOP_INIT: begin
          if (cmd_q == CMD_CLOCK_ON) state_d = ST_F3_CLK_ON;
          else if (cmd_q == CMD_DEACT_CLK_OFF) state_d = ST_F3_CLK_OFF;
          else if (frame_aligned_q && rx_info == RX_INFO3)
            state_d = ST_LOOP_ACTIVE;
        end
        ST_LOOP_ACTIVE,
        ST_TEST_PULSE: begin
          // Test modes end only on clock-on, deactivate or layer 1 reset
          if (cmd_q == CMD_CLOCK_ON) state_d = ST_F3_CLK_ON;
          else if (cmd_q == CMD_DEACT_CLK_OFF) state_d = ST_F3_CLK_OFF;
        end
        default: state_d = ST_F3_CLK_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_F3_CLK_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Indication register, refreshed from the next state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      indication_code_register <= IND_CLOCKS_OFF;
      ind_valid_q <= 1'b1;
    end else begin
      indication_code_register <= ind_of(state_d, class2_q, rx_level);
      ind_valid_q <= (state_d != ST_L1_RESET);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command_code_register <= CMD_RESET_VALUE;
    end else begin
      command_code_register <= cmd_q;
    end
  end

  // ==========================================================
  // Line transmit control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_info_q <= TX_INFO0;
      tx_line_en_q <= 1'b1;
      loop_en_q <= 1'b0;
      awake_det_en_q <= 1'b1;
      clocks_en_q <= 1'b0;
      pulse_mode_q <= PULSE_NONE;
    end else begin
      case (state_d)
        ST_F4_AWAIT_SIG: tx_info_q <= TX_INFO1;
        ST_F6_SYNC,
        ST_F7_ACTIVE,
        ST_LOOP_INIT,
        ST_LOOP_ACTIVE: tx_info_q <= TX_INFO3;
        default: tx_info_q <= TX_INFO0;
      endcase
      // Loop keeps INFO 3 internal; the line sees INFO 0
      tx_line_en_q <= (state_d != ST_LOOP_INIT) &&
                      (state_d != ST_LOOP_ACTIVE);
      loop_en_q <= (state_d == ST_LOOP_INIT) ||
                   (state_d == ST_LOOP_ACTIVE);
      awake_det_en_q <= (state_d != ST_L1_RESET);
      clocks_en_q <= (state_d != ST_F3_CLK_OFF);
      if (state_d != ST_TEST_PULSE) begin
        pulse_mode_q <= PULSE_NONE;
      end else if (cmd_q == CMD_CONT_PULSE) begin
        pulse_mode_q <= PULSE_CONT;
      end else if (cmd_q == CMD_SINGLE_PULSE) begin
        pulse_mode_q <= PULSE_SINGLE;
      end
    end
  end

  l1ac_pulse_gen #(
    .CP_CYC(CP_PULSE_CYC),
    .SP_CYC(SP_CYC),
    .W_CYC(BIT_CYC)
  ) l1ac_pulse_gen_inst (
    .clk(clk),
    .rst(rst),
    .mode(pulse_mode_q),
    .pulse_pos_q(tx_pulse_pos_q),
    .pulse_neg_q(tx_pulse_neg_q)
  );

  // ==========================================================
  // D channel access: collision and priority
  assign collide = d_bit_strobe && d_tx_busy && !d_stop_q &&
                   (d_tx_bit != d_echo_bit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d_collision_q <= 1'b0;
      d_stop_q <= 1'b0;
    end else begin
      d_collision_q <= collide;
      if (collide) begin
        d_stop_q <= 1'b1;
      end else if (!d_tx_busy) begin
        d_stop_q <= 1'b0;
      end
    end
  end

  // Consecutive echo ones seen; saturates at the highest level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ones_cnt_q <= '0;
    end else if (d_bit_strobe) begin
      if (!d_echo_bit || (d_tx_busy && !d_stop_q)) begin
        ones_cnt_q <= '0;
      end else if (ones_cnt_q < PRIO_CLASS2_LOWER) begin
        ones_cnt_q <= ones_cnt_q + 4'h1;
      end
    end
  end

  // Lower level after a sent frame, normal again once it is reached
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_q <= 1'b0;
    end else if (d_frame_done) begin
      lower_q <= 1'b1;
    end else if (ones_cnt_q >= d_prio_q) begin
      lower_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d_prio_q <= PRIO_CLASS1_NORMAL;
      d_access_ok_q <= 1'b0;
    end else begin
      case ({class2_q, lower_q})
        2'b00: d_prio_q <= PRIO_CLASS1_NORMAL;
        2'b01: d_prio_q <= PRIO_CLASS1_LOWER;
        2'b10: d_prio_q <= PRIO_CLASS2_NORMAL;
        default: d_prio_q <= PRIO_CLASS2_LOWER;
      endcase
      d_access_ok_q <= (state_q == ST_F7_ACTIVE) &&
                       (ones_cnt_q >= d_prio_q) && !d_stop_q;
    end
  end

endmodule // l1ac_top

/* sim/l1ac_nt_model.sv */
// Network termination stand-in: frame ticks, FA bits, line signal
`timescale 1ns/100ps
module l1ac_nt_model import l1ac_pkg::*; #(
  parameter int FRM_CYC = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire l1ac_rx_info_t info,
  input wire logic bad,
  output l1ac_rx_info_t rx_info,
  output logic rx_frame_tick,
  output logic rx_frame_ok,
  output logic rx_fa_bit,
  output logic rx_level
);
  int cnt;
  logic fa_n;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      fa_n <= 1'b0;
      rx_info <= RX_INFO0;
      rx_frame_tick <= 1'b0;
      rx_frame_ok <= 1'b0;
      rx_fa_bit <= 1'b0;
      rx_level <= 1'b0;
    end else begin
      cnt <= (cnt == FRM_CYC - 1) ? 0 : cnt + 1;
      rx_info <= info;
      rx_level <= (info != RX_INFO0);
      rx_frame_tick <= (cnt == 0);
      // Qualifiers only valid on the tick, so they wander elsewhere
      rx_frame_ok <= (cnt == 0) ? !bad : !rx_frame_ok;
      rx_fa_bit <= (cnt == 0) ? fa_n : !rx_fa_bit;
      if (cnt == 0) fa_n <= !fa_n;
    end
  end
endmodule // l1ac_nt_model

/* sim/l1ac_top_monitor.sv */
// Concurrent checks on the layer 1 control ports
`timescale 1ns/100ps
module l1ac_top_monitor import l1ac_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_wr,
  input wire logic [3:0] cmd_data,
  input wire logic rx_frame_tick,
  input wire logic rx_frame_ok,
  input wire logic rx_fa_bit,
  input wire logic d_bit_strobe,
  input wire logic d_tx_bit,
  input wire logic d_echo_bit,
  input wire logic d_tx_busy,
  input wire logic [3:0] command_code_register,
  input wire logic [3:0] indication_code_register,
  input wire logic ind_valid_q,
  input wire l1ac_state_t state_q,
  input wire l1ac_tx_info_t tx_info_q,
  input wire logic tx_line_en_q,
  input wire logic loop_en_q,
  input wire logic awake_det_en_q,
  input wire logic tx_fa_q,
  input wire logic frame_aligned_q,
  input wire logic [3:0] d_prio_q,
  input wire logic d_collision_q,
  input wire logic d_stop_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Consecutive bad and good frame counts
  logic [2:0] bad_q;
  logic [2:0] good_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bad_q <= 3'h0;
      good_q <= 3'h0;
    end else if (rx_frame_tick) begin
      bad_q <= rx_frame_ok ? 3'h0 : 3'h1 + {2'h0, |bad_q};
      good_q <= !rx_frame_ok ? 3'h0 : good_q + {2'h0, good_q < 3'h5};
    end
  end
  // ==========
  // Checks
  a_reset_quiet: assert property (
    state_q == ST_L1_RESET |-> !ind_valid_q && !awake_det_en_q
    && tx_info_q == TX_INFO0) else $error("reset state not quiet");
  a_clk_on_state: assert property (
    state_q == ST_F3_CLK_ON |-> indication_code_register == 4'h7
    && tx_info_q == TX_INFO0) else $error("clock-on outputs wrong");
  a_clk_off_ind: assert property (
    state_q == ST_F3_CLK_OFF |-> indication_code_register == 4'hf)
    else $error("clock-off indication wrong");
  a_loop_internal: assert property (
    loop_en_q |-> !tx_line_en_q) else $error("loop reaches line");
  a_active_class: assert property (
    state_q == ST_F7_ACTIVE |-> indication_code_register ==
    (d_prio_q[1] ? 4'hd : 4'hc)) else $error("active class wrong");
  a_cmd_taken: assert property (
    cmd_wr |-> ##2 command_code_register == $past(cmd_data, 2))
    else $error("command not taken");
  a_cmd_held: assert property (
    !cmd_wr [*2] |=> $stable(command_code_register))
    else $error("command not held");
  a_collision_stop: assert property (
    d_bit_strobe && d_tx_busy && !d_stop_q && d_tx_bit != d_echo_bit
    |=> d_collision_q ##[0:1] d_stop_q) else $error("collision missed");
  a_fa_mirror: assert property (
    rx_frame_tick |=> tx_fa_q == $past(rx_fa_bit))
    else $error("FA bit not mirrored");
  a_one_bad_kept: assert property (
    rx_frame_tick && !rx_frame_ok && bad_q == 3'h0 && frame_aligned_q
    |=> frame_aligned_q [*2]) else $error("alignment lost early");
  a_two_bad_lost: assert property (
    rx_frame_tick && !rx_frame_ok && bad_q == 3'h1
    |-> ##[1:2] !frame_aligned_q) else $error("alignment kept");
  a_regain_fifth: assert property (
    rx_frame_tick && rx_frame_ok && good_q == 3'h4
    |-> ##[1:2] frame_aligned_q) else $error("alignment not regained");
  c_active: cover property (state_q == ST_F7_ACTIVE);
  c_collision: cover property (d_collision_q);
  c_loop: cover property (loop_en_q);
endmodule // l1ac_top_monitor

/* sim/l1ac_top_tb.sv */
// Self-checking bench for the layer 1 activation control block
`timescale 1ns/100ps
module l1ac_top_tb import l1ac_pkg::*;;
  localparam int SPC = 3000;
  typedef struct packed {
    logic wr; logic [3:0] c; l1ac_rx_info_t i; l1ac_state_t s; logic [3:0] ind;
  } l1ac_row_t;
  logic clk = 0;
  logic rst = 1;
  logic cmd_wr = 0;
  logic [3:0] cmd_data = 4'h0;
  logic [3:0] command_code_register, indication_code_register, d_prio_q;
  logic ind_valid_q, tx_line_en_q, loop_en_q, awake_det_en_q, clocks_en_q;
  logic tx_fa_q, frame_aligned_q, tx_pulse_pos_q, tx_pulse_neg_q;
  logic d_access_ok_q, d_collision_q, d_stop_q, col_seen = 0;
  l1ac_state_t state_q;
  l1ac_tx_info_t tx_info_q;
  l1ac_rx_info_t rx_info, info = RX_INFO0;
  logic rx_frame_tick, rx_frame_ok, rx_fa_bit, rx_level, bad = 0;
  logic d_bit_strobe = 0, d_tx_bit = 0, d_echo_bit = 0;
  logic d_tx_busy = 0, d_frame_done = 0;
  int failures = 0, n_checks = 0, cyc = 0, n;
  l1ac_row_t rows [10] = '{
    '{1, 4'h0, RX_INFO0, ST_F3_CLK_ON, 4'h7},
    '{1, 4'h8, RX_INFO0, ST_F4_AWAIT_SIG, 4'h7},
    '{0, 4'h8, RX_ANY, ST_F5_IDENTIFY, 4'h4},
    '{0, 4'h8, RX_INFO2, ST_F6_SYNC, 4'h8},
    '{0, 4'h8, RX_INFO4, ST_F7_ACTIVE, 4'hc},
    '{0, 4'h8, RX_INFO0, ST_F3_AWAIT_DEACT, 4'h0},
    '{1, 4'hf, RX_INFO0, ST_F3_CLK_OFF, 4'hf},
    '{1, 4'h0, RX_INFO0, ST_F3_CLK_ON, 4'h7},
    '{1, 4'h9, RX_INFO0, ST_F4_AWAIT_SIG, 4'h7},
    '{0, 4'h9, RX_INFO4, ST_F7_ACTIVE, 4'hd}
  };
  l1ac_top #(.SP_CYC(SPC), .INFO0_DEACT_FRAMES(4)) l1ac_top_inst (.*);
  l1ac_nt_model l1ac_nt_model_inst (.*);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (d_collision_q === 1'b1) col_seen = 1;
    // Budget well above the longest pulse measurement
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic cmd(input logic [3:0] c);
    wt(1);
    cmd_data = c;
    cmd_wr = 1;
    wt(1);
    cmd_wr = 0;
    wt(3);
  endtask
  task automatic frm(input logic b, input int k);
    bad = b;
    repeat (k) do @(posedge clk); while (!rx_frame_tick);
    wt(3);
  endtask
  task automatic strb(input logic t, input logic e);
    d_tx_bit = t;
    d_echo_bit = e;
    d_bit_strobe = 1;
    wt(1);
    d_bit_strobe = 0;
    d_echo_bit = ~e;
    wt(2);
  endtask
  task automatic meas(input logic single);
    do wt(1); while (tx_pulse_pos_q);
    do wt(1); while (!tx_pulse_pos_q);
    n = 0;
    do begin
      wt(1);
      n++;
    end while (single ? !tx_pulse_neg_q : tx_pulse_pos_q);
  endtask
  // ==========
  // Main sequence
  initial begin
    wt(5);
    rst = 0;
    wt(2);
    chk(state_q, ST_F3_CLK_OFF);
    chk(command_code_register, 4'hf);
    chk(d_prio_q, 4'h8);
    chk(clocks_en_q, 0);
    foreach (rows[k]) begin
      info = rows[k].i;
      if (rows[k].wr) cmd(rows[k].c);
      wt(100);
      chk(state_q, rows[k].s);
      chk(indication_code_register, rows[k].ind);
    end
    chk(clocks_en_q, 1);
    $display("rows done");
    frm(1, 1);
    chk(frame_aligned_q, 1);
    frm(0, 1);
    frm(1, 2);
    chk(frame_aligned_q, 0);
    chk(state_q, ST_F8_LOST_FRAME);
    frm(0, 4);
    chk(frame_aligned_q, 0);
    frm(0, 1);
    wt(4);
    chk(frame_aligned_q, 1);
    chk(state_q, ST_F7_ACTIVE);
    $display("framing done");
    chk(d_prio_q, 4'ha);
    d_tx_busy = 1;
    strb(1, 1);
    chk(col_seen, 0);
    strb(0, 1);
    chk(col_seen, 1);
    chk(d_stop_q, 1);
    d_tx_busy = 0;
    wt(2);
    chk(d_stop_q, 0);
    d_frame_done = 1;
    wt(1);
    d_frame_done = 0;
    wt(2);
    chk(d_prio_q, 4'hb);
    repeat (12) strb(1, 1);
    chk(d_prio_q, 4'ha);
    chk(d_access_ok_q, 1);
    $display("d channel done");
    cmd(4'h1);
    chk(state_q, ST_L1_RESET);
    chk(ind_valid_q, 0);
    chk(awake_det_en_q, 0);
    info = RX_INFO2;
    cmd(4'h8);
    wt(20);
    chk(state_q, ST_L1_RESET);
    info = RX_INFO0;
    cmd(4'h0);
    wt(20);
    chk(state_q, ST_F3_CLK_ON);
    $display("layer reset done");
    cmd(4'h4);
    chk(indication_code_register, 4'ha);
    meas(0);
    chk(n, CP_PULSE_CYC);
    chk(tx_pulse_neg_q, 1);
    info = RX_INFO2;
    wt(20);
    chk(indication_code_register, 4'hb);
    info = RX_INFO0;
    cmd(4'h0);
    cmd(4'h2);
    meas(1);
    chk(n, SPC);
    cmd(4'h0);
    chk(state_q, ST_F3_CLK_ON);
    cmd(4'ha);
    wt(100);
    chk(loop_en_q, 1);
    chk(tx_line_en_q, 0);
    info = RX_INFO3;
    wt(20);
    chk(state_q, ST_LOOP_ACTIVE);
    chk(indication_code_register, 4'hb);
    $display("test modes done");
    // Mid-run reset must bring the block back to idle
    rst = 1;
    info = RX_INFO0;
    wt(2);
    rst = 0;
    wt(2);
    chk(state_q, ST_F3_CLK_OFF);
    chk(indication_code_register, 4'hf);
    chk(clocks_en_q, 0);
    chk(loop_en_q, 0);
    $display("second reset done");
    test_done();
  end
endmodule // l1ac_top_tb
bind l1ac_top l1ac_top_monitor l1ac_top_monitor_inst (.*);
